/* File: bpp_map.vh */
// Register map, field positions and reset values of the port block.
// Assumes an 8-bit register bus with a 4-bit word index as address.
`ifndef BPP_MAP_VH
`define BPP_MAP_VH

// Register indices
`define BPP_ADDR_W          4
`define BPP_IDX_B_LEVELS    4'h0
`define BPP_IDX_B_LATCH     4'h1
`define BPP_IDX_B_DIR       4'h2
`define BPP_IDX_C_LEVELS    4'h3
`define BPP_IDX_C_LATCH     4'h4
`define BPP_IDX_C_DIR       4'h5
`define BPP_IDX_INT_MAIN    4'h6
`define BPP_IDX_INT_EDGES   4'h7
`define BPP_IDX_INT_PINS    4'h8
`define BPP_IDX_ANALOG_CFG  4'h9

// Field positions
`define BPP_BIT_CHANGE_FLAG 0
`define BPP_BIT_CHANGE_EN   3
`define BPP_BIT_PULLUP_DIS  7
`define BPP_BIT_ANALOG_SEL3 3
`define BPP_PIN_ANALOG      4
`define BPP_PIN_LVP         5
`define BPP_PIN_PROG_CLK    6
`define BPP_PIN_PROG_LINE   7
`define BPP_CHG_LO          4
`define BPP_CHG_HI          7

// Implemented-bit masks; other bits read as zero
`define BPP_MASK_INT_MAIN   8'hFF
`define BPP_MASK_INT_EDGES  8'hF5
`define BPP_MASK_INT_PINS   8'hDB
`define BPP_MASK_ANALOG     8'h3F

// Reset values
`define BPP_RST_ZERO        8'h00
`define BPP_RST_DIR         8'hFF
`define BPP_RST_INT_EDGES   8'hF5
`define BPP_RST_ANALOG      8'h00

`endif

/* File: bpp_sync.v */
// Two-stage synchroniser for a bus of independent pin levels.
// Assumes each bit is a slow level; no bus coherence is promised.
`timescale 1ns/1ps

module bpp_sync #(
	parameter WIDTH = 8
) (
	input  wire             clk_i,
	input  wire             reset_n_i,
	input  wire [WIDTH-1:0] async_i,
	output wire [WIDTH-1:0] sync_o
);

	reg [WIDTH-1:0] meta_q;
	reg [WIDTH-1:0] sync_q;

	// First stage feeds only the second stage
	always @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			meta_q <= {WIDTH{1'b0}};
			sync_q <= {WIDTH{1'b0}};
		end
		else
		begin
			meta_q <= async_i;
			sync_q <= meta_q;
		end
	end

	assign sync_o = sync_q;

endmodule // bpp_sync

/* File: bpp_top.v */
// Two 8-bit bidirectional ports with direction, latch and level registers.
// Assumes pins and peripheral requests arrive synchronous-ish to REF_CLK_I;
// pin levels are resynchronised anyway before any logic looks at them.
//
// What this block does
// - Direction bit one turns the pin driver off; the pin is an input.
// - Direction bit zero drives the pin from its output latch bit.
// - Latch register is addressable and reads back the latch, not the pin.
// - First-port pull-ups act only on digital input pins.
// - Pin four starts analog after reset and then reads as zero.
// - Low-voltage programming entry on pin five turns its driver off.
// - In programming mode pin seven drives the serial programming line while PROG_LINE_DRIVE_I is set, else it is an input.
// - In programming mode pin six is the serial programming clock input.
// - After reset all second-port pins are inputs, direction bits set.
// - An enabled peripheral overrides a pin's effective direction.
// - Direction register reads return stored bits despite overrides.
// - Upper input pins differing from the snapshot of the last level-register read or write set the change flag.
// - Reading the level register refreshes the snapshot; flag stays set.
// - Clearing the active-low pull-up bit enables the pull-ups of first-port digital input pins.
// - Pull-ups are off on output pins and disabled by every reset.
`timescale 1ns/1ps
`include "bpp_map.vh"

module bpp_top #(
	parameter WIDTH = 8
) (
	input  wire                  REF_CLK_I,
	input  wire                  RESET_N_I,
	// Register port
	input  wire [`BPP_ADDR_W-1:0] REG_ADDR_I,
	input  wire [WIDTH-1:0]      REG_WDATA_I,
	input  wire                  REG_WR_I,
	input  wire                  REG_RD_I,
	output wire [WIDTH-1:0]      REG_RDATA_O,
	// First port pins
	input  wire [WIDTH-1:0]      PB_PIN_I,
	output wire [WIDTH-1:0]      PB_PIN_O,
	output wire [WIDTH-1:0]      PB_PIN_OE_N_O,
	output wire [WIDTH-1:0]      PB_PULLUP_O,
	// First port peripheral takeover
	input  wire [WIDTH-1:0]      PB_PERIPH_EN_I,
	input  wire [WIDTH-1:0]      PB_PERIPH_DIR_I,
	input  wire [WIDTH-1:0]      PB_PERIPH_OUT_I,
	output wire [WIDTH-1:0]      PB_LEVEL_O,
	// Second port pins
	input  wire [WIDTH-1:0]      PC_PIN_I,
	output wire [WIDTH-1:0]      PC_PIN_O,
	output wire [WIDTH-1:0]      PC_PIN_OE_N_O,
	// Second port peripheral takeover
	input  wire [WIDTH-1:0]      PC_PERIPH_EN_I,
	input  wire [WIDTH-1:0]      PC_PERIPH_DIR_I,
	input  wire [WIDTH-1:0]      PC_PERIPH_OUT_I,
	output wire [WIDTH-1:0]      PC_LEVEL_O,
	// Programming functions
	input  wire                  LVP_ENTRY_EN_I,
	input  wire                  PROG_MODE_I,
	input  wire                  PROG_LINE_OUT_I,
	input  wire                  PROG_LINE_DRIVE_I,
	output wire                  PROG_CLOCK_O,
	output wire                  PROG_LINE_IN_O,
	output wire                  LVP_ENTRY_O,
	// Change detection and analog select
	output wire                  CHANGE_FLAG_O,
	output wire                  ANALOG_NINE_SEL_O
);

	// Effective driven value: peripheral wins where enabled
	function [WIDTH-1:0] bpp_out_val;
		input [WIDTH-1:0] latch;
		input [WIDTH-1:0] p_en;
		input [WIDTH-1:0] p_out;
		begin
			bpp_out_val = (p_en & p_out) | (~p_en & latch);
		end
	endfunction

	// Effective direction, one meaning input
	function [WIDTH-1:0] bpp_dir_eff;
		input [WIDTH-1:0] dir;
		input [WIDTH-1:0] p_en;
		input [WIDTH-1:0] p_dir;
		begin
			bpp_dir_eff = (p_en & p_dir) | (~p_en & dir);
		end
	endfunction

	// Register storage
	reg  [WIDTH-1:0] b_latch_q;
	reg  [WIDTH-1:0] b_dir_q;
	reg  [WIDTH-1:0] c_latch_q;
	reg  [WIDTH-1:0] c_dir_q;
	reg  [WIDTH-1:0] int_main_q;
	reg  [WIDTH-1:0] int_edges_q;
	reg  [WIDTH-1:0] int_pins_q;
	reg  [WIDTH-1:0] analog_cfg_q;
	reg  [WIDTH-1:0] snap_q;
	reg  [WIDTH-1:0] rdata_q;

	// Registered pin-facing outputs
	reg  [WIDTH-1:0] b_pin_q;
	reg  [WIDTH-1:0] b_oe_n_q;
	reg  [WIDTH-1:0] b_pullup_q;
	reg  [WIDTH-1:0] b_level_q;
	reg  [WIDTH-1:0] c_pin_q;
	reg  [WIDTH-1:0] c_oe_n_q;
	reg  [WIDTH-1:0] c_level_q;
	reg              prog_clk_q;
	reg              prog_line_q;
	reg              lvp_entry_q;
	reg              analog_sel_q;

	// Combinational helpers
	wire [WIDTH-1:0] b_sync;
	wire [WIDTH-1:0] c_sync;
	reg  [WIDTH-1:0] b_levels_d;
	reg  [WIDTH-1:0] b_pin_d;
	reg  [WIDTH-1:0] b_oe_n_d;
	reg  [WIDTH-1:0] b_pullup_d;
	reg  [WIDTH-1:0] rdata_d;
	wire [WIDTH-1:0] b_dir_e;
	wire [WIDTH-1:0] c_dir_e;
	wire             analog_nine;
	wire             wr_b_lvl;
	wire             rd_b_lvl;
	wire             mismatch;
	wire             flag_clr;

	// Pin levels resynchronised before any use
	bpp_sync #(
		.WIDTH(WIDTH)
	) u_sync_b (
		.clk_i    (REF_CLK_I),
		.reset_n_i(RESET_N_I),
		.async_i  (PB_PIN_I),
		.sync_o   (b_sync)
	);

	bpp_sync #(
		.WIDTH(WIDTH)
	) u_sync_c (
		.clk_i    (REF_CLK_I),
		.reset_n_i(RESET_N_I),
		.async_i  (PC_PIN_I),
		.sync_o   (c_sync)
	);

	// Analog select bit clear keeps pin four on the converter
	assign analog_nine = ~analog_cfg_q[`BPP_BIT_ANALOG_SEL3];
	assign b_dir_e     = bpp_dir_eff(b_dir_q, PB_PERIPH_EN_I, PB_PERIPH_DIR_I);
	assign c_dir_e     = bpp_dir_eff(c_dir_q, PC_PERIPH_EN_I, PC_PERIPH_DIR_I);
	assign wr_b_lvl    = REG_WR_I && (REG_ADDR_I == `BPP_IDX_B_LEVELS);
	assign rd_b_lvl    = REG_RD_I && (REG_ADDR_I == `BPP_IDX_B_LEVELS);

	// First-port levels as software sees them; analog pin reads low
	always @*
	begin
		b_levels_d = b_sync;
		if (analog_nine)
			b_levels_d[`BPP_PIN_ANALOG] = 1'b0;
	end

	// Mismatch only on upper pins that are effective inputs
	assign mismatch = |((b_levels_d[`BPP_CHG_HI:`BPP_CHG_LO]
		^ snap_q[`BPP_CHG_HI:`BPP_CHG_LO])
		& b_dir_e[`BPP_CHG_HI:`BPP_CHG_LO]);

	assign flag_clr = REG_WR_I && (REG_ADDR_I == `BPP_IDX_INT_MAIN)
		&& !REG_WDATA_I[`BPP_BIT_CHANGE_FLAG];

	// First-port driver, enable and pull-up decisions
	always @*
	begin
		b_pin_d    = bpp_out_val(b_latch_q, PB_PERIPH_EN_I, PB_PERIPH_OUT_I);
		b_oe_n_d   = b_dir_e;
		b_pullup_d = b_dir_e & {WIDTH{~int_edges_q[`BPP_BIT_PULLUP_DIS]}};
		if (analog_nine)
			b_pullup_d[`BPP_PIN_ANALOG] = 1'b0;
		// Entry function takes the pin away from the digital driver
		if (LVP_ENTRY_EN_I)
			b_oe_n_d[`BPP_PIN_LVP] = 1'b1;
		if (PROG_MODE_I)
		begin
			b_oe_n_d[`BPP_PIN_PROG_CLK]    = 1'b1;
			b_pullup_d[`BPP_PIN_PROG_CLK]  = 1'b0;
			b_oe_n_d[`BPP_PIN_PROG_LINE]   = ~PROG_LINE_DRIVE_I;
			b_pin_d[`BPP_PIN_PROG_LINE]    = PROG_LINE_OUT_I;
			b_pullup_d[`BPP_PIN_PROG_LINE] = 1'b0;
		end
		if (LVP_ENTRY_EN_I)
			b_pullup_d[`BPP_PIN_LVP] = 1'b0;
	end

	// Read multiplexer; unmapped indices read zero
	always @*
	begin
		case (REG_ADDR_I)
		`BPP_IDX_B_LEVELS:   rdata_d = b_levels_d;
		`BPP_IDX_B_LATCH:    rdata_d = b_latch_q;
		`BPP_IDX_B_DIR:      rdata_d = b_dir_q;
		`BPP_IDX_C_LEVELS:   rdata_d = c_sync;
		`BPP_IDX_C_LATCH:    rdata_d = c_latch_q;
		`BPP_IDX_C_DIR:      rdata_d = c_dir_q;
		`BPP_IDX_INT_MAIN:   rdata_d = int_main_q;
		`BPP_IDX_INT_EDGES:  rdata_d = int_edges_q;
		`BPP_IDX_INT_PINS:   rdata_d = int_pins_q;
		`BPP_IDX_ANALOG_CFG: rdata_d = analog_cfg_q;
		default:             rdata_d = `BPP_RST_ZERO;
		endcase
	end

	// Software-written registers
	always @(posedge REF_CLK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
		begin
			b_latch_q    <= `BPP_RST_ZERO;
			b_dir_q      <= `BPP_RST_DIR;
			c_latch_q    <= `BPP_RST_ZERO;
			c_dir_q      <= `BPP_RST_DIR;
			int_edges_q  <= `BPP_RST_INT_EDGES;
			int_pins_q   <= `BPP_RST_ZERO;
			analog_cfg_q <= `BPP_RST_ANALOG;
		end
		else if (REG_WR_I)
		begin
			case (REG_ADDR_I)
			// Level register writes land in the latch, as on a port write
			`BPP_IDX_B_LEVELS:   b_latch_q <= REG_WDATA_I;
			`BPP_IDX_B_LATCH:    b_latch_q <= REG_WDATA_I;
			`BPP_IDX_B_DIR:      b_dir_q   <= REG_WDATA_I;
			`BPP_IDX_C_LEVELS:   c_latch_q <= REG_WDATA_I;
			`BPP_IDX_C_LATCH:    c_latch_q <= REG_WDATA_I;
			`BPP_IDX_C_DIR:      c_dir_q   <= REG_WDATA_I;
			`BPP_IDX_INT_EDGES:
				int_edges_q  <= REG_WDATA_I & `BPP_MASK_INT_EDGES;
			`BPP_IDX_INT_PINS:
				int_pins_q   <= REG_WDATA_I & `BPP_MASK_INT_PINS;
			`BPP_IDX_ANALOG_CFG:
				analog_cfg_q <= REG_WDATA_I & `BPP_MASK_ANALOG;
			default:
				b_dir_q <= b_dir_q;
			endcase
		end
	end

	// Main control register; hardware set of the change flag beats clear
	always @(posedge REF_CLK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
			int_main_q <= `BPP_RST_ZERO;
		else
		begin
			if (REG_WR_I && (REG_ADDR_I == `BPP_IDX_INT_MAIN))
				int_main_q <= REG_WDATA_I & `BPP_MASK_INT_MAIN;
			// Flag may only be cleared, never set, by software alone
			if (mismatch)
				int_main_q[`BPP_BIT_CHANGE_FLAG] <= 1'b1;
			else if (flag_clr)
				int_main_q[`BPP_BIT_CHANGE_FLAG] <= 1'b0;
			else
				int_main_q[`BPP_BIT_CHANGE_FLAG] <=
					int_main_q[`BPP_BIT_CHANGE_FLAG];
		end
	end

	// Snapshot refreshed by any access of the level register
	always @(posedge REF_CLK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
			snap_q <= `BPP_RST_ZERO;
		else if (rd_b_lvl || wr_b_lvl)
			snap_q <= b_levels_d;
	end

	// Read data stands only in the cycle after the strobe
	always @(posedge REF_CLK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
			rdata_q <= `BPP_RST_ZERO;
		else if (REG_RD_I)
			rdata_q <= rdata_d;
		else
			rdata_q <= `BPP_RST_ZERO;
	end

	// Pin drivers registered; drivers off during reset
	always @(posedge REF_CLK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
		begin
			b_pin_q      <= `BPP_RST_ZERO;
			b_oe_n_q     <= `BPP_RST_DIR;
			b_pullup_q   <= `BPP_RST_ZERO;
			b_level_q    <= `BPP_RST_ZERO;
			c_pin_q      <= `BPP_RST_ZERO;
			c_oe_n_q     <= `BPP_RST_DIR;
			c_level_q    <= `BPP_RST_ZERO;
			prog_clk_q   <= 1'b0;
			prog_line_q  <= 1'b0;
			lvp_entry_q  <= 1'b0;
			analog_sel_q <= 1'b1;
		end
		else
		begin
			b_pin_q      <= b_pin_d;
			b_oe_n_q     <= b_oe_n_d;
			b_pullup_q   <= b_pullup_d;
			b_level_q    <= b_sync;
			c_pin_q      <= bpp_out_val(c_latch_q, PC_PERIPH_EN_I,
				PC_PERIPH_OUT_I);
			c_oe_n_q     <= c_dir_e;
			c_level_q    <= c_sync;
			prog_clk_q   <= PROG_MODE_I & b_sync[`BPP_PIN_PROG_CLK];
			prog_line_q  <= PROG_MODE_I & b_sync[`BPP_PIN_PROG_LINE];
			lvp_entry_q  <= LVP_ENTRY_EN_I & b_sync[`BPP_PIN_LVP];
			analog_sel_q <= analog_nine;
		end
	end

	// Outputs straight from flip-flops
	assign REG_RDATA_O       = rdata_q;
	assign PB_PIN_O          = b_pin_q;
	assign PB_PIN_OE_N_O     = b_oe_n_q;
	assign PB_PULLUP_O       = b_pullup_q;
	assign PB_LEVEL_O        = b_level_q;
	assign PC_PIN_O          = c_pin_q;
	assign PC_PIN_OE_N_O     = c_oe_n_q;
	assign PC_LEVEL_O        = c_level_q;
	assign PROG_CLOCK_O      = prog_clk_q;
	assign PROG_LINE_IN_O    = prog_line_q;
	assign LVP_ENTRY_O       = lvp_entry_q;
	assign CHANGE_FLAG_O     = int_main_q[`BPP_BIT_CHANGE_FLAG];
	assign ANALOG_NINE_SEL_O = analog_sel_q;

endmodule // bpp_top

/* File: bpp_board.sv */
// Board model for one port: resolves each pin from all its sources.
// Assumes one clock; an undriven pin shows a level that flips each cycle.
`timescale 1ns/1ps

module bpp_board (
	input  wire       clk_i,
	input  wire [7:0] pin_o_i,
	input  wire [7:0] oe_n_i,
	input  wire [7:0] pull_i,
	input  wire [7:0] ext_en_i,
	input  wire [7:0] ext_val_i,
	output wire [7:0] level_o
);
	reg [7:0] flt_q = 8'h55;

	// Floating lines toggle so a stale level never passes
	always @(posedge clk_i)
		flt_q <= ~flt_q;

	// Device drive wins, then the board source, then the pull-up
	assign level_o = (~oe_n_i & pin_o_i)
		| (oe_n_i & ext_en_i & ext_val_i)
		| (oe_n_i & ~ext_en_i & pull_i)
		| (oe_n_i & ~ext_en_i & ~pull_i & flt_q);
endmodule // bpp_board

/* File: bpp_top_sva.sv */
// Checker for the port block, watching its top-level ports only.
// Assumes one clock domain and the register map header.
`timescale 1ns/1ps
`include "bpp_map.vh"

module bpp_chk (
	input wire                   REF_CLK_I,
	input wire                   RESET_N_I,
	input wire [`BPP_ADDR_W-1:0] REG_ADDR_I,
	input wire                   REG_WR_I,
	input wire                   REG_RD_I,
	input wire [7:0]             REG_RDATA_O,
	input wire [7:0]             PB_PIN_O,
	input wire [7:0]             PB_PIN_OE_N_O,
	input wire [7:0]             PB_PULLUP_O,
	input wire [7:0]             PC_PERIPH_EN_I,
	input wire [7:0]             PC_PERIPH_DIR_I,
	input wire [7:0]             PC_PERIPH_OUT_I,
	input wire [7:0]             PC_PIN_O,
	input wire [7:0]             PC_PIN_OE_N_O,
	input wire                   LVP_ENTRY_EN_I,
	input wire                   PROG_MODE_I,
	input wire                   PROG_LINE_OUT_I,
	input wire                   PROG_LINE_DRIVE_I,
	input wire                   PROG_CLOCK_O,
	input wire                   CHANGE_FLAG_O,
	input wire                   ANALOG_NINE_SEL_O
);
	reg [7:0] fo_q;
	reg [7:0] fi_q;
	reg [7:0] pv_q;

	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (!RESET_N_I);

	// Last cycle's peripheral requests, in step with the registered pins
	always @(posedge REF_CLK_I or negedge RESET_N_I)
		if (!RESET_N_I)
		begin
			fo_q <= 8'h00;
			fi_q <= 8'h00;
			pv_q <= 8'h00;
		end
		else
		begin
			fo_q <= PC_PERIPH_EN_I & ~PC_PERIPH_DIR_I;
			fi_q <= PC_PERIPH_EN_I & PC_PERIPH_DIR_I;
			pv_q <= PC_PERIPH_OUT_I;
		end

	property p_rd_idle;
		!REG_RD_I |=> REG_RDATA_O == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data not idle");
	property p_force_out;
		(fo_q & (PC_PIN_OE_N_O | (PC_PIN_O ^ pv_q))) == 8'h00;
	endproperty
	a_force_out: assert property (p_force_out)
		else $error("peripheral output not on pin");
	property p_force_in;
		(fi_q & ~PC_PIN_OE_N_O) == 8'h00;
	endproperty
	a_force_in: assert property (p_force_in)
		else $error("peripheral input still driven");
	property p_lvp;
		LVP_ENTRY_EN_I |=> PB_PIN_OE_N_O[5];
	endproperty
	a_lvp: assert property (p_lvp)
		else $error("pin five driven in entry mode");
	property p_line;
		PROG_MODE_I && PROG_LINE_DRIVE_I |=> !PB_PIN_OE_N_O[7]
			&& PB_PIN_O[7] == $past(PROG_LINE_OUT_I);
	endproperty
	a_line: assert property (p_line)
		else $error("programming line not driven");
	property p_pclk;
		PROG_MODE_I |=> PB_PIN_OE_N_O[6];
	endproperty
	a_pclk: assert property (p_pclk)
		else $error("programming clock pin driven");
	property p_pclk_gate;
		!PROG_MODE_I |=> !PROG_CLOCK_O;
	endproperty
	a_pclk_gate: assert property (p_pclk_gate)
		else $error("programming clock outside mode");
	property p_pull_out;
		(PB_PULLUP_O & ~PB_PIN_OE_N_O) == 8'h00;
	endproperty
	a_pull_out: assert property (p_pull_out)
		else $error("pull-up on a driven pin");
	property p_ana_pull;
		ANALOG_NINE_SEL_O |-> !PB_PULLUP_O[4];
	endproperty
	a_ana_pull: assert property (p_ana_pull)
		else $error("pull-up on analog pin");
	property p_flag_hold;
		CHANGE_FLAG_O && !(REG_WR_I && REG_ADDR_I == `BPP_IDX_INT_MAIN)
			|=> CHANGE_FLAG_O;
	endproperty
	a_flag_hold: assert property (p_flag_hold)
		else $error("change flag dropped by itself");
endmodule // bpp_chk

bind bpp_top bpp_chk u_chk (
	.REF_CLK_I(REF_CLK_I), .RESET_N_I(RESET_N_I),
	.REG_ADDR_I(REG_ADDR_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
	.REG_RDATA_O(REG_RDATA_O), .PB_PIN_O(PB_PIN_O),
	.PB_PIN_OE_N_O(PB_PIN_OE_N_O), .PB_PULLUP_O(PB_PULLUP_O),
	.PC_PERIPH_EN_I(PC_PERIPH_EN_I), .PC_PERIPH_DIR_I(PC_PERIPH_DIR_I),
	.PC_PERIPH_OUT_I(PC_PERIPH_OUT_I), .PC_PIN_O(PC_PIN_O),
	.PC_PIN_OE_N_O(PC_PIN_OE_N_O), .LVP_ENTRY_EN_I(LVP_ENTRY_EN_I),
	.PROG_MODE_I(PROG_MODE_I), .PROG_LINE_OUT_I(PROG_LINE_OUT_I),
	.PROG_LINE_DRIVE_I(PROG_LINE_DRIVE_I), .PROG_CLOCK_O(PROG_CLOCK_O),
	.CHANGE_FLAG_O(CHANGE_FLAG_O), .ANALOG_NINE_SEL_O(ANALOG_NINE_SEL_O)
);

/* File: bidirectional_port_pins_bench.sv */
// Register-level bench for the port block with a board model per port.
// Assumes the map header; peripheral takeover is driven on both ports.
`timescale 1ns/1ps
`include "bpp_map.vh"

module bidirectional_port_pins_bench;
	reg        clk = 1'b0;
	reg        rst_n = 1'b0;
	reg  [3:0] addr = 4'h0;
	reg  [7:0] wdata = 8'h00;
	reg        wr = 1'b0;
	reg        rd = 1'b0;
	reg  [7:0] c_en = 8'h00;
	reg  [7:0] c_dir = 8'h00;
	reg  [7:0] c_out = 8'h00;
	reg        lvp_en = 1'b0;
	reg        pmode = 1'b0;
	reg        pline = 1'b0;
	reg        pdrv = 1'b0;
	reg  [7:0] b_ext = 8'hF0;
	reg  [7:0] b_pen = 8'h00;
	reg  [7:0] b_pdir = 8'h00;
	reg  [7:0] b_pout = 8'h00;
	wire [7:0] rdata, b_pin, b_o, b_oe_n, b_pull, b_lvl;
	wire [7:0] c_pin, c_o, c_oe_n, c_lvl;
	wire       pclk, lvp_o, flag, ana, pl_in;
	integer    n_errors = 0;
	integer    total_checks = 0;
	integer    i;

	// 200 MHz clock
	always #2.5 clk = ~clk;

	bpp_top DUT (
		.REF_CLK_I(clk), .RESET_N_I(rst_n), .REG_ADDR_I(addr),
		.REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd),
		.REG_RDATA_O(rdata), .PB_PIN_I(b_pin), .PB_PIN_O(b_o),
		.PB_PIN_OE_N_O(b_oe_n), .PB_PULLUP_O(b_pull),
		.PB_PERIPH_EN_I(b_pen), .PB_PERIPH_DIR_I(b_pdir),
		.PB_PERIPH_OUT_I(b_pout), .PB_LEVEL_O(b_lvl), .PC_PIN_I(c_pin),
		.PC_PIN_O(c_o), .PC_PIN_OE_N_O(c_oe_n), .PC_PERIPH_EN_I(c_en),
		.PC_PERIPH_DIR_I(c_dir), .PC_PERIPH_OUT_I(c_out),
		.PC_LEVEL_O(c_lvl),
		.LVP_ENTRY_EN_I(lvp_en), .PROG_MODE_I(pmode),
		.PROG_LINE_OUT_I(pline), .PROG_LINE_DRIVE_I(pdrv),
		.PROG_CLOCK_O(pclk), .PROG_LINE_IN_O(pl_in), .LVP_ENTRY_O(lvp_o),
		.CHANGE_FLAG_O(flag), .ANALOG_NINE_SEL_O(ana)
	);
	bpp_board u_pb (.clk_i(clk), .pin_o_i(b_o), .oe_n_i(b_oe_n),
		.pull_i(b_pull), .ext_en_i(8'hF8), .ext_val_i(b_ext),
		.level_o(b_pin));
	bpp_board u_pc (.clk_i(clk), .pin_o_i(c_o), .oe_n_i(c_oe_n),
		.pull_i(8'h00), .ext_en_i(8'h00), .ext_val_i(8'h00),
		.level_o(c_pin));

	task complete_run;
		begin
			$display("checks %0d, mismatches %0d", total_checks, n_errors);
			if (n_errors == 0 && total_checks > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask

	task cmp(input [7:0] g, input [7:0] e);
		begin
			total_checks = total_checks + 1;
			if (g !== e)
			begin
				n_errors = n_errors + 1;
				$display("CHECK FAILED at %0t: got %h, expected %h",
					$time, g, e);
			end
		end
	endtask

	task idle(input integer n);
		repeat (n) @(posedge clk);
	endtask

	// One-cycle strobes; a free edge follows each so none is set twice
	task wr_reg(input [3:0] a, input [7:0] d);
		begin
			@(posedge clk);
			wr <= 1'b1;
			addr <= a;
			wdata <= d;
			@(posedge clk);
			wr <= 1'b0;
		end
	endtask

	task rd_chk(input [3:0] a, input [7:0] e);
		begin
			@(posedge clk);
			rd <= 1'b1;
			addr <= a;
			@(posedge clk);
			rd <= 1'b0;
			// Data stand only in this cycle; look mid-cycle
			@(negedge clk);
			cmp(rdata, e);
			@(posedge clk);
		end
	endtask

	// Bounded wait for the change flag
	task wait_flag;
		begin
			i = 0;
			while (flag !== 1'b1 && i < 20)
			begin
				@(posedge clk);
				i = i + 1;
			end
			if (flag !== 1'b1)
			begin
				cmp(8'h00, 8'h01);
				complete_run;
			end
		end
	endtask

	// Main sequence
	initial
	begin
		idle(4);
		rst_n <= 1'b1;
		rd_chk(`BPP_IDX_B_DIR, 8'hFF);
		rd_chk(`BPP_IDX_C_DIR, 8'hFF);
		rd_chk(`BPP_IDX_INT_EDGES, 8'hF5);
		rd_chk(`BPP_IDX_ANALOG_CFG, 8'h00);
		rd_chk(4'hA, 8'h00);
		cmp({7'h00, ana}, 8'h01);
		cmp(b_oe_n, 8'hFF);
		// Low nibble from the latch, high nibble from the board
		wr_reg(`BPP_IDX_B_LATCH, 8'h5A);
		wr_reg(`BPP_IDX_B_DIR, 8'hF0);
		idle(3);
		cmp(b_oe_n, 8'hF0);
		cmp(b_o & 8'h0F, 8'h0A);
		rd_chk(`BPP_IDX_B_LATCH, 8'h5A);
		rd_chk(`BPP_IDX_B_LEVELS, 8'hEA);
		wr_reg(`BPP_IDX_INT_MAIN, 8'h00);
		rd_chk(`BPP_IDX_INT_MAIN, 8'h00);
		// Input change sets the flag; read alone does not clear it
		b_ext <= 8'h70;
		wait_flag;
		rd_chk(`BPP_IDX_B_LEVELS, 8'h6A);
		idle(2);
		cmp({7'h00, flag}, 8'h01);
		wr_reg(`BPP_IDX_INT_MAIN, 8'h00);
		idle(1);
		cmp({7'h00, flag}, 8'h00);
		// An output pin changing is left out of the compare
		wr_reg(`BPP_IDX_B_DIR, 8'h70);
		wr_reg(`BPP_IDX_B_LATCH, 8'hDA);
		idle(6);
		cmp({7'h00, flag}, 8'h00);
		wr_reg(`BPP_IDX_INT_EDGES, 8'h75);
		idle(2);
		cmp(b_pull, 8'h60);
		wr_reg(`BPP_IDX_ANALOG_CFG, 8'h08);
		idle(2);
		cmp(b_pull, 8'h70);
		cmp({7'h00, ana}, 8'h00);
		rd_chk(`BPP_IDX_B_LEVELS, 8'hFA);
		rd_chk(`BPP_IDX_INT_EDGES, 8'h75);
		wr_reg(`BPP_IDX_INT_PINS, 8'hFF);
		rd_chk(`BPP_IDX_INT_PINS, 8'hDB);
		wr_reg(`BPP_IDX_B_LEVELS, 8'h5A);
		rd_chk(`BPP_IDX_B_LATCH, 8'h5A);
		// Programming overrides with every pin set to output
		wr_reg(`BPP_IDX_B_DIR, 8'h00);
		lvp_en <= 1'b1;
		pmode <= 1'b1;
		pdrv <= 1'b1;
		pline <= 1'b1;
		idle(5);
		cmp(b_oe_n & 8'hE0, 8'h60);
		cmp({7'h00, b_o[7]}, 8'h01);
		cmp({5'h00, pl_in, pclk, lvp_o}, 8'h07);
		lvp_en <= 1'b0;
		pmode <= 1'b0;
		pdrv <= 1'b0;
		// Second port: latch drive, then peripheral takeover
		wr_reg(`BPP_IDX_C_LATCH, 8'h3C);
		wr_reg(`BPP_IDX_C_DIR, 8'h00);
		idle(3);
		cmp(c_o, 8'h3C);
		rd_chk(`BPP_IDX_C_LEVELS, 8'h3C);
		cmp(c_lvl, 8'h3C);
		c_en <= 8'hFF;
		c_dir <= 8'h0F;
		c_out <= 8'hA5;
		idle(2);
		cmp(c_oe_n, 8'h0F);
		cmp(c_o & 8'hF0, 8'hA0);
		rd_chk(`BPP_IDX_C_DIR, 8'h00);
		// Latch low so only the board can raise pin three
		wr_reg(`BPP_IDX_B_LATCH, 8'h00);
		wr_reg(`BPP_IDX_B_DIR, 8'h08);
		b_ext <= 8'hE8;
		b_pen <= 8'h04;
		b_pout <= 8'h04;
		idle(5);
		cmp(b_lvl & 8'h08, 8'h08);
		cmp(b_oe_n & 8'h0C, 8'h08);
		cmp(b_o & 8'h04, 8'h04);
		rd_chk(`BPP_IDX_B_DIR, 8'h08);
		// Second reset in mid-run
		rst_n <= 1'b0;
		idle(4);
		rst_n <= 1'b1;
		idle(1);
		cmp(b_pull, 8'h00);
		rd_chk(`BPP_IDX_B_DIR, 8'hFF);
		rd_chk(`BPP_IDX_B_LATCH, 8'h00);
		complete_run;
	end
endmodule // bidirectional_port_pins_bench
